// file: rtl/tpc_timer_prescaler.sv
// Shared prescaler, external clock sampling and 8-bit compare flags with APB registers
//
// Added by the designer: the register addresses and the APB interface to the registers.
`include "tpc_consts.svh"
`default_nettype none
module tpc_timer_prescaler
   import tpc_pkg::*;
(
   // Clock and reset
   input wire logic refClk,
   input wire logic reset,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // CPU side
   input wire logic globalIrqEnable,
   input wire logic overflowVectorTaken,
   input wire logic compareVectorTaken,
   output logic overflowIrq,
   output logic compareIrq,
   // Counter core link
   input wire logic [7:0] counterValue8bit,
   input wire logic counterWrap,
   input wire logic counterBottomTurn,
   input wire logic [1:0] waveMode,
   output logic compareMatch,
   output logic [7:0] compareValue8bit,
   // Timer clock enables: 0 = 8-bit timer, 1 = timer1, 2 = timer3
   output logic [2:0] timerTick,
   output logic asyncPrescalerReset,
   // External clock pins for timer0 and timer1
   input wire logic [1:0] externalClockPin
);

   // Tap index for a clock select value; third timer maps 6/7 to /16 and /32
   function automatic logic tapHit(input logic [2:0] sel, input logic [9:0] cnt,
                                   input logic third);
      logic hit;
      hit = 1'b0;
      case (sel)
         CS_DIRECT: hit = 1'b1;
         CS_DIV8: hit = (cnt[2:0] == 3'h7);
         CS_DIV64: hit = (cnt[5:0] == 6'h3F);
         CS_DIV256: hit = (cnt[7:0] == 8'hFF);
         CS_DIV1024: hit = (cnt == 10'h3FF);
         CS_EXT_FALL: hit = third & (cnt[3:0] == 4'hF);
         CS_EXT_RISE: hit = third & (cnt[4:0] == 5'h1F);
         default: hit = 1'b0;
      endcase
      return hit;
   endfunction

   // Register state
   logic [7:0] compareQ, compareD;
   logic [7:0] maskQ, maskD;
   logic ovfFlagQ, ovfFlagD, cmpFlagQ, cmpFlagD;
   logic tsmQ, tsmD, psrQ, psrD, apsrQ, apsrD;
   logic [5:0] otherSfcQ, otherSfcD;
   logic [8:0] clkSelQ, clkSelD;
   logic [9:0] prescaleQ, prescaleD;
   logic [31:0] prdataQ, prdataD;
   logic [2:0] syncA0Q, syncB0Q, syncC0Q, syncA1Q, syncB1Q, syncC1Q;
   logic [1:0] pinLevelQ, pinLevelD, pinPrevQ;
   logic cmpPrevQ;
   logic wrEn, rdEn, addrOk;
   logic [2:0] sel0, sel1, sel3;
   logic [1:0] rise, fall;

   assign wrEn = psel & penable & pwrite;
   // Read data is registered in the setup cycle so it stands at the access edge
   assign rdEn = psel & ~penable & ~pwrite;
   assign addrOk = (paddr == `TPC_OFS_COMPARE) || (paddr == `TPC_OFS_MASK) ||
                   (paddr == `TPC_OFS_FLAGS) || (paddr == `TPC_OFS_SFC) ||
                   (paddr == `TPC_OFS_CLKSEL) || (paddr == `TPC_OFS_STATUS);
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~addrOk;
   assign prdata = prdataQ;
   assign sel0 = clkSelQ[2:0];
   assign sel1 = clkSelQ[5:3];
   assign sel3 = clkSelQ[8:6];

   // Compare match pulses on the first cycle the counter value equals the compare value
   assign compareMatch = (counterValue8bit == compareQ) & ~cmpPrevQ;
   assign compareValue8bit = compareQ;
   assign asyncPrescalerReset = apsrQ;

   // Interrupt requests
   assign overflowIrq = maskQ[`TPC_BIT_OVF] & globalIrqEnable & ovfFlagQ;
   assign compareIrq = maskQ[`TPC_BIT_CMP] & globalIrqEnable & cmpFlagQ;

   // Edge detection on the third-stage level, no prescaler on this path
   assign rise = pinLevelQ & ~pinPrevQ;
   assign fall = ~pinLevelQ & pinPrevQ;

   // Timer tick selection
   always_comb begin
      timerTick[0] = tapHit(sel0, prescaleQ, 1'b0);
      timerTick[1] = tapHit(sel1, prescaleQ, 1'b0);
      timerTick[2] = tapHit(sel3, prescaleQ, 1'b1);
      if (sel0 == CS_EXT_RISE) begin
         timerTick[0] = rise[0];
      end else if (sel0 == CS_EXT_FALL) begin
         timerTick[0] = fall[0];
      end
      if (sel1 == CS_EXT_RISE) begin
         timerTick[1] = rise[1];
      end else if (sel1 == CS_EXT_FALL) begin
         timerTick[1] = fall[1];
      end
      if (psrQ) begin
         timerTick = 3'h0;
      end
   end

   // Register file next state
   always_comb begin
      compareD = compareQ;
      maskD = maskQ;
      tsmD = tsmQ;
      psrD = tsmQ ? psrQ : 1'b0;
      apsrD = tsmQ ? apsrQ : 1'b0;
      otherSfcD = otherSfcQ;
      clkSelD = clkSelQ;
      ovfFlagD = ovfFlagQ;
      cmpFlagD = cmpFlagQ;
      prdataD = prdataQ;
      if (overflowVectorTaken) begin
         ovfFlagD = 1'b0;
      end
      if (compareVectorTaken) begin
         cmpFlagD = 1'b0;
      end
      if (wrEn) begin
         case (paddr)
            `TPC_OFS_COMPARE: compareD = pwdata[7:0];
            `TPC_OFS_MASK: maskD = pwdata[7:0];
            `TPC_OFS_FLAGS: begin
               if (pwdata[`TPC_BIT_OVF]) begin
                  ovfFlagD = 1'b0;
               end
               if (pwdata[`TPC_BIT_CMP]) begin
                  cmpFlagD = 1'b0;
               end
            end
            `TPC_OFS_SFC: begin
               tsmD = pwdata[`TPC_BIT_TSM];
               otherSfcD = pwdata[6:1];
               psrD = pwdata[`TPC_BIT_PSR] & pwdata[`TPC_BIT_TSM];
               apsrD = pwdata[`TPC_BIT_APSR];
            end
            `TPC_OFS_CLKSEL: clkSelD = pwdata[8:0];
            default: ;
         endcase
         // Writing one to the reset bit outside sync mode pulses it once
         if (paddr == `TPC_OFS_SFC && !pwdata[`TPC_BIT_TSM]) begin
            psrD = pwdata[`TPC_BIT_PSR];
            apsrD = pwdata[`TPC_BIT_APSR];
            if (tsmQ) begin
               psrD = 1'b0;
               apsrD = 1'b0;
            end
         end
      end
      // Hardware sets win over any clear in the same cycle
      if ((waveMode == WG_PHASE_PWM) ? counterBottomTurn : counterWrap) begin
         ovfFlagD = 1'b1;
      end
      if (compareMatch) begin
         cmpFlagD = 1'b1;
      end
      if (rdEn) begin
         case (paddr)
            `TPC_OFS_COMPARE: prdataD = {24'h000000, compareQ};
            `TPC_OFS_MASK: prdataD = {24'h000000, maskQ};
            `TPC_OFS_FLAGS: prdataD = {30'h00000000, ovfFlagQ, cmpFlagQ};
            `TPC_OFS_SFC: prdataD = {24'h000000, tsmQ, otherSfcQ[5:1], apsrQ, psrQ};
            `TPC_OFS_CLKSEL: prdataD = {23'h000000, clkSelQ};
            `TPC_OFS_STATUS: prdataD = {22'h000000, prescaleQ};
            default: prdataD = 32'h00000000;
         endcase
      end
   end

   // Free-running prescaler, cleared only by reset and the shared reset bit
   always_comb begin
      prescaleD = prescaleQ + 10'h001;
      if (psrQ) begin
         prescaleD = 10'h000;
      end
   end

   // Pin sampling: latch stage, two registers, level taken when they agree
   always_comb begin
      pinLevelD = pinLevelQ;
      if (syncB0Q[0] == syncC0Q[0]) begin
         pinLevelD[0] = syncC0Q[0];
      end
      if (syncB1Q[0] == syncC1Q[0]) begin
         pinLevelD[1] = syncC1Q[0];
      end
   end

   // State registers
   always_ff @(posedge refClk) begin
      if (reset) begin
         compareQ <= `TPC_RST_COMPARE;
         maskQ <= `TPC_RST_MASK;
         tsmQ <= 1'b0;
         psrQ <= 1'b0;
         apsrQ <= 1'b0;
         otherSfcQ <= 6'h00;
         clkSelQ <= 9'h000;
         ovfFlagQ <= 1'b0;
         cmpFlagQ <= 1'b0;
         prdataQ <= 32'h00000000;
         prescaleQ <= 10'h000;
         syncA0Q <= 3'h0;
         syncB0Q <= 3'h0;
         syncC0Q <= 3'h0;
         syncA1Q <= 3'h0;
         syncB1Q <= 3'h0;
         syncC1Q <= 3'h0;
         pinLevelQ <= 2'h0;
         pinPrevQ <= 2'h0;
         cmpPrevQ <= 1'b0;
      end else begin
         compareQ <= compareD;
         maskQ <= maskD;
         tsmQ <= tsmD;
         psrQ <= psrD;
         apsrQ <= apsrD;
         otherSfcQ <= otherSfcD;
         clkSelQ <= clkSelD;
         ovfFlagQ <= ovfFlagD;
         cmpFlagQ <= cmpFlagD;
         prdataQ <= prdataD;
         prescaleQ <= prescaleD;
         syncA0Q <= {2'h0, externalClockPin[0]};
         syncB0Q <= syncA0Q;
         syncC0Q <= syncB0Q;
         syncA1Q <= {2'h0, externalClockPin[1]};
         syncB1Q <= syncA1Q;
         syncC1Q <= syncB1Q;
         pinLevelQ <= pinLevelD;
         pinPrevQ <= pinLevelQ;
         cmpPrevQ <= (counterValue8bit == compareQ);
      end
   end

endmodule // tpc_timer_prescaler
`default_nettype wire

// file: rtl/tpc_consts.svh
// Offsets, field positions, reset values and the prescaler width for the timer prescaler block
`ifndef TPC_CONSTS_SVH
`define TPC_CONSTS_SVH
`define TPC_OFS_COMPARE 12'h000
`define TPC_OFS_MASK 12'h004
`define TPC_OFS_FLAGS 12'h008
`define TPC_OFS_SFC 12'h00C
`define TPC_OFS_CLKSEL 12'h010
`define TPC_OFS_STATUS 12'h014
`define TPC_BIT_CMP 0
`define TPC_BIT_OVF 1
`define TPC_BIT_PSR 0
`define TPC_BIT_APSR 1
`define TPC_BIT_TSM 7
`define TPC_RST_COMPARE 8'h00
`define TPC_RST_MASK 8'h00
`define TPC_RST_SFC 8'h00
`define TPC_PRESCALE_W 10
`endif

// file: rtl/tpc_pkg.sv
// Types shared by the timer prescaler block
`default_nettype none
package tpc_pkg;
   typedef enum logic [2:0] {
      CS_STOP = 3'h0, CS_DIRECT = 3'h1, CS_DIV8 = 3'h2, CS_DIV64 = 3'h3,
      CS_DIV256 = 3'h4, CS_DIV1024 = 3'h5, CS_EXT_FALL = 3'h6, CS_EXT_RISE = 3'h7
   } tpc_clksel_t;
   typedef enum logic [1:0] {
      WG_NORMAL = 2'h0, WG_PHASE_PWM = 2'h1, WG_CTC = 2'h2, WG_FAST_PWM = 2'h3
   } tpc_wgm_t;
endpackage : tpc_pkg
`default_nettype wire

// file: verification/tpc_ext_src.sv
// External clock source model for the timer input pins
`default_nettype none
module tpc_ext_src
(
   // Pacing clock
   input wire logic refClk,
   // Pins for timer0 and timer1
   output logic [1:0] extPin
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle low, stable outside bursts
   initial extPin = 2'h0;
   // Full periods, each half longer than one cycle
   task automatic burst(input int n, input int half);
      repeat (n) begin
         @(posedge refClk);
         extPin <= 2'h3;
         repeat (half) @(posedge refClk);
         extPin <= 2'h0;
         repeat (half - 1) @(posedge refClk);
      end
   endtask
endmodule // tpc_ext_src
`default_nettype wire

// file: verification/tpc_timer_prescaler_chk.sv
// Checker watching the timer prescaler block ports
`include "tpc_consts.svh"
`default_nettype none
module tpc_chk
   import tpc_pkg::*;
(
   // Clock and bus
   input wire logic refClk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic pready,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   // Timer side
   input wire logic globalIrqEnable,
   input wire logic counterWrap,
   input wire logic counterBottomTurn,
   input wire logic [1:0] waveMode,
   input wire logic [7:0] counterValue8bit,
   input wire logic [7:0] compareValue8bit,
   input wire logic compareMatch,
   input wire logic overflowIrq,
   input wire logic compareIrq,
   input wire logic [2:0] timerTick,
   input wire logic [1:0] externalClockPin
);
   timeunit 1ns;
   timeprecision 1ps;
   logic wr;
   logic [1:0] mask_q, mask_d;
   logic [8:0] sel_q, sel_d;
   logic tsm_q, tsm_d, psr_q, psr_d;
   default clocking dc @(posedge refClk); endclocking
   default disable iff (reset);
   // Mirror of mask, select and prescaler reset
   always_comb begin
      wr = psel && penable && pwrite && pready;
      mask_d = (wr && paddr == `TPC_OFS_MASK) ? pwdata[1:0] : mask_q;
      sel_d = (wr && paddr == `TPC_OFS_CLKSEL) ? pwdata[8:0] : sel_q;
      tsm_d = (wr && paddr == `TPC_OFS_SFC) ? pwdata[7] : tsm_q;
      psr_d = (wr && paddr == `TPC_OFS_SFC) ? pwdata[0] : (tsm_q && psr_q);
   end
   always_ff @(posedge refClk) begin
      mask_q <= reset ? 2'h0 : mask_d;
      sel_q <= reset ? 9'h000 : sel_d;
      tsm_q <= reset ? 1'b0 : tsm_d;
      psr_q <= reset ? 1'b0 : psr_d;
   end
   sequence s_rise0;
      $rose(externalClockPin[0]) && sel_q[2:0] == CS_EXT_RISE;
   endsequence
   sequence s_fall1;
      $fell(externalClockPin[1]) && sel_q[5:3] == CS_EXT_FALL;
   endsequence
   a_cmp_equal: assert property (compareMatch |-> counterValue8bit == compareValue8bit)
      else $error("compare pulse without equal values");
   a_ovf_gate: assert property (overflowIrq |-> globalIrqEnable && mask_q[1])
      else $error("overflow request not gated");
   a_cmp_gate: assert property (compareIrq |-> globalIrqEnable && mask_q[0])
      else $error("compare request not gated");
   a_ovf_wrap: assert property (counterWrap && waveMode != WG_PHASE_PWM && mask_q[1]
      |=> overflowIrq || !globalIrqEnable) else $error("wrap did not set overflow");
   a_ovf_turn: assert property (counterBottomTurn && waveMode == WG_PHASE_PWM && mask_q[1]
      |=> overflowIrq || !globalIrqEnable) else $error("turnaround did not set overflow");
   a_cmp_flag: assert property (compareMatch && mask_q[0] |=> compareIrq || !globalIrqEnable)
      else $error("match did not set compare flag");
   a_direct_tick: assert property (sel_q[2:0] == CS_DIRECT && !psr_q |-> timerTick[0])
      else $error("direct select missed a tick");
   a_div8_gap: assert property (timerTick[1] && sel_q[5:3] == CS_DIV8 |=> !timerTick[1] [*7])
      else $error("divide by eight tick too early");
   a_sync_halt: assert property (psr_q |-> timerTick == 3'h0)
      else $error("tick while prescaler held");
   a_rise_tick: assert property (s_rise0 |-> ##[2:6] timerTick[0])
      else $error("rising pin edge gave no tick");
   a_fall_tick: assert property (s_fall1 |-> ##[2:6] timerTick[1])
      else $error("falling pin edge gave no tick");
   a_stop_quiet: assert property (sel_q[2:0] == CS_STOP |-> !timerTick[0])
      else $error("stopped timer ticked");
endmodule // tpc_chk
bind tpc_timer_prescaler tpc_chk CHK (.refClk, .reset, .psel, .penable, .pwrite, .pready,
   .paddr, .pwdata, .globalIrqEnable, .counterWrap, .counterBottomTurn, .waveMode,
   .counterValue8bit, .compareValue8bit, .compareMatch, .overflowIrq, .compareIrq,
   .timerTick, .externalClockPin);
`default_nettype wire

// file: verification/tb_timer_prescaler_and_compare_flags.sv
// Testbench for the timer prescaler and compare flag block
`include "tpc_consts.svh"
`default_nettype none
module tb_timer_prescaler_and_compare_flags;
   timeunit 1ns;
   timeprecision 1ps;
   logic refClk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic globalIrqEnable = 1'b0, ovVec = 1'b0, cmpVec = 1'b0, wrap = 1'b0, turn = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [7:0] cnt = 8'h01, cmpVal;
   logic [1:0] waveMode = 2'h0, extPin;
   logic [2:0] timerTick;
   logic pready, pslverr, ovfIrq, cmpIrq, cmpMatch, asyncRst, errSeen;
   int miscompares = 0, checks = 0, cycles = 0, t0, t1, t3;
   int sh[4] = '{3, 6, 8, 10};
   tpc_timer_prescaler DUT (.refClk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .globalIrqEnable, .overflowVectorTaken(ovVec),
      .compareVectorTaken(cmpVec), .overflowIrq(ovfIrq), .compareIrq(cmpIrq),
      .counterValue8bit(cnt), .counterWrap(wrap), .counterBottomTurn(turn), .waveMode,
      .compareMatch(cmpMatch), .compareValue8bit(cmpVal), .timerTick,
      .asyncPrescalerReset(asyncRst), .externalClockPin(extPin));
   tpc_ext_src EXT (.refClk, .extPin);
   always #4 refClk = ~refClk;
   // Hang guard
   always @(posedge refClk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         tally_and_finish();
      end
   end
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // One APB transfer, read data lands in rd
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge refClk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge refClk);
      penable <= 1'b1;
      do @(posedge refClk); while (pready !== 1'b1);
      errSeen = pslverr;
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // One-cycle event pulse, then flags read back
   task automatic hit(input logic [3:0] v, input logic [7:0] c);
      @(posedge refClk);
      {wrap, turn, ovVec, cmpVec} <= v;
      cnt <= c;
      @(posedge refClk);
      {wrap, turn, ovVec, cmpVec} <= 4'h0;
      cnt <= 8'h01;
      apb(1'b0, `TPC_OFS_FLAGS, 32'h0);
   endtask
   task automatic count(input int n);
      t0 = 0;
      t1 = 0;
      t3 = 0;
      repeat (n) begin
         @(negedge refClk);
         t0 += timerTick[0];
         t1 += timerTick[1];
         t3 += timerTick[2];
      end
   endtask
   task automatic tally_and_finish();
      $display("checks=%0d miscompares=%0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge refClk);
      reset <= 1'b0;
      for (int i = 0; i < 16; i += 4) begin
         apb(1'b0, 12'(i), 32'h0);
         chk(rd, 32'h0);
      end
      apb(1'b0, 12'h020, 32'h0);
      chk({errSeen, rd}, 33'h100000000);
      apb(1'b1, `TPC_OFS_COMPARE, 32'hA5);
      apb(1'b1, `TPC_OFS_MASK, 32'h3);
      @(posedge refClk);
      globalIrqEnable <= 1'b1;
      hit(4'h0, 8'hA5);
      chk({cmpIrq, rd}, 33'h100000001);
      @(posedge refClk);
      globalIrqEnable <= 1'b0;
      @(negedge refClk);
      chk(cmpIrq, 1'b0);
      apb(1'b1, `TPC_OFS_FLAGS, 32'h0);
      hit(4'h0, 8'h01);
      chk(rd, 32'h1);
      globalIrqEnable <= 1'b1;
      apb(1'b1, `TPC_OFS_FLAGS, 32'h1);
      hit(4'h8, 8'h01);
      chk({ovfIrq, rd}, 33'h100000002);
      hit(4'h2, 8'h01);
      chk(rd, 32'h0);
      waveMode <= 2'h1;
      hit(4'h8, 8'h01);
      chk(rd, 32'h0);
      hit(4'h4, 8'hA5);
      chk(rd, 32'h3);
      hit(4'h3, 8'h01);
      chk(rd, 32'h0);
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, `TPC_OFS_CLKSEL, {23'h0, (i == 0) ? 3'h6 : 3'h7, 3'h2, 3'(i + 2)});
         count(2048);
         chk(t0, 2048 >> sh[i]);
         chk(t1, 256);
         chk(t3, (i == 0) ? 128 : 64);
      end
      apb(1'b1, `TPC_OFS_CLKSEL, 32'h1);
      apb(1'b1, `TPC_OFS_SFC, 32'h1);
      apb(1'b0, `TPC_OFS_SFC, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, `TPC_OFS_SFC, 32'h83);
      count(32);
      chk({asyncRst, t0[7:0]}, 9'h100);
      apb(1'b0, `TPC_OFS_SFC, 32'h0);
      chk(rd, 32'h83);
      apb(1'b1, `TPC_OFS_SFC, 32'h0);
      count(32);
      chk(t0, 32);
      apb(1'b0, `TPC_OFS_SFC, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, `TPC_OFS_CLKSEL, 32'h37);
      fork
         count(60);
         EXT.burst(5, 3);
      join
      chk({t0[7:0], t1[7:0]}, 16'h0505);
      tally_and_finish();
   end
endmodule // tb_timer_prescaler_and_compare_flags
`default_nettype wire
